// file: design/fis_pkg.sv
// constants shared by both ends of the id / parameter-table link
// assumes a 10 MHz system clock on each end and a single-bit spi link
package fis_pkg;

  // instruction codes
  localparam logic [7:0] OP_UNIQUE = 8'h4b;
  localparam logic [7:0] OP_IDENT  = 8'h9f;
  localparam logic [7:0] OP_TABLE  = 8'h5a;
  localparam logic [7:0] OP_SLEEP  = 8'hb9;
  localparam logic [7:0] OP_WAKE   = 8'hab;

  // last bit index of each header phase, counted on rising link edges
  localparam logic [5:0] LAST_OPC_BIT   = 6'h07;
  localparam logic [5:0] LAST_ADDR_BIT  = 6'h17;
  localparam logic [5:0] LAST_UID_DUMMY = 6'h1f;
  localparam logic [5:0] LAST_TBL_DUMMY = 6'h07;
  // bits the host sends before data returns
  localparam logic [5:0] HDR_SHORT      = 6'h08;
  localparam logic [5:0] HDR_LONG       = 6'h28;

  // identity defaults; all values arbitrary
  localparam logic [63:0] UID_DEFAULT   = 64'h0123_4567_89ab_cdef;
  localparam logic [7:0]  MAKER_DEFAULT = 8'h5c;
  localparam logic [7:0]  MEMTYPE_DEF   = 8'h40;
  localparam logic [7:0]  CAPACITY_DEF  = 8'h18;

  // discoverable-parameter table: offsets and contents
  localparam logic [7:0] T_SIG0   = 8'h00, V_SIG0   = 8'h53;
  localparam logic [7:0] T_SIG1   = 8'h01, V_SIG1   = 8'h46;
  localparam logic [7:0] T_SIG2   = 8'h02, V_SIG2   = 8'h44;
  localparam logic [7:0] T_SIG3   = 8'h03, V_SIG3   = 8'h50;
  localparam logic [7:0] T_MINOR  = 8'h04, V_MINOR  = 8'h01;
  localparam logic [7:0] T_MAJOR  = 8'h05, V_MAJOR  = 8'h01;
  localparam logic [7:0] T_NHDR   = 8'h06, V_NHDR   = 8'h00;
  localparam logic [7:0] T_BMAKER = 8'h08;
  localparam logic [7:0] T_BMINOR = 8'h09, V_BMINOR = 8'h00;
  localparam logic [7:0] T_BMAJOR = 8'h0a, V_BMAJOR = 8'h01;
  localparam logic [7:0] T_BLEN   = 8'h0b, V_BLEN   = 8'h04;
  localparam logic [7:0] T_BPTR0  = 8'h0c, V_BPTR0  = 8'h80;
  localparam logic [7:0] T_BPTR1  = 8'h0d, V_BPTR1  = 8'h00;
  localparam logic [7:0] T_BPTR2  = 8'h0e, V_BPTR2  = 8'h00;
  localparam logic [7:0] T_PMAKER = 8'h10;
  localparam logic [7:0] T_PMINOR = 8'h11, V_PMINOR = 8'h00;
  localparam logic [7:0] T_PMAJOR = 8'h12, V_PMAJOR = 8'h01;
  localparam logic [7:0] T_PLEN   = 8'h13, V_PLEN   = 8'h00;
  localparam logic [7:0] T_PPTR0  = 8'h14, V_PPTR0  = 8'h90;
  localparam logic [7:0] T_PPTR1  = 8'h15, V_PPTR1  = 8'h00;
  localparam logic [7:0] T_PPTR2  = 8'h16, V_PPTR2  = 8'h00;
  localparam logic [7:0] V_RSVD   = 8'hff;

  // timing
  localparam int CLK_PERIOD_NS  = 100;
  localparam int SCLK_PERIOD_NS = 800;
  localparam int CS_GAP_NS      = 400;
  localparam int SCLK_DIV       = SCLK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [2:0] PH_RISE = 3'(SCLK_DIV / 2 - 1);
  localparam logic [2:0] PH_LAST = 3'(SCLK_DIV - 1);
  localparam logic [2:0] GAP_LAST =
    3'((CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1);

  // host apb registers
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RX_LO  = 8'h08;
  localparam logic [7:0] REG_RX_HI  = 8'h0c;
  localparam int CTRL_OP_LSB   = 0;
  localparam int CTRL_ADDR_LSB = 8;
  localparam int CTRL_CNT_LSB  = 16;
  localparam int CTRL_START    = 31;
  localparam int ST_BUSY       = 0;
  localparam int ST_DONE       = 1;

  typedef enum logic [4:0] {
    D_OPC    = 5'h01,
    D_ADDR   = 5'h02,
    D_DUMMY  = 5'h04,
    D_SEND   = 5'h08,
    D_IGNORE = 5'h10
  } fis_dstate_e;

  typedef enum logic [2:0] {
    H_IDLE = 3'h1,
    H_RUN  = 3'h2,
    H_GAP  = 3'h4
  } fis_hstate_e;

endpackage

// file: design/fis_link_if.sv
// single-bit spi link between the host controller and the device
// assumes the bench joins both modports; only the device drives miso
`timescale 1ns/100ps
interface fis_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso_drv;
  logic miso_oe;
  wire  miso_line;

  // a released line reads high, as through a pull-up
  assign miso_line = miso_oe ? miso_drv : 1'b1;

  modport dev  (input cs_n, sclk, mosi, output miso_drv, miso_oe);
  modport host (output cs_n, sclk, mosi, input miso_line);
endinterface

// file: design/fis_device.sv
// device end: decodes unique-id, identity and parameter-table reads
// assumes link pins are asynchronous to clock_in; all are synchronised
`timescale 1ns/100ps

module fis_device
  import fis_pkg::*;
#(
  parameter logic [63:0] UNIQUE_ID   = UID_DEFAULT,
  parameter logic [7:0]  MAKER_CODE  = MAKER_DEFAULT,
  parameter logic [7:0]  MEMORY_TYPE = MEMTYPE_DEF,
  parameter logic [7:0]  CAPACITY    = CAPACITY_DEF
) (
  input  wire logic   clock_in,
  input  wire logic   reset_n_in,
  fis_link_if.dev     link,
  output logic        powered_down_out
);

  typedef struct packed {
    logic        sclk_meta;
    logic        sclk_sync;
    logic        sclk_prev;
    logic        cs_meta;
    logic        cs_sync;
    logic        si_meta;
    logic        si_sync;
    fis_dstate_e state;
    logic [7:0]  opcode;
    logic [5:0]  bit_cnt;
    logic [7:0]  addr;
    logic [7:0]  idx;
    logic [2:0]  out_bit;
    logic        sleep;
    logic        sleep_pend;
    logic        wake_pend;
    logic        miso;
    logic        miso_oe;
  } fis_dev_s;

  fis_dev_s   r;
  fis_dev_s   next_r;
  logic       rise;
  logic       fall;
  logic [7:0] op_now;
  logic [7:0] cur_byte;

  // table contents; undefined locations and the table body read FFh
  function automatic logic [7:0] table_byte(input logic [7:0] a);
    logic [7:0] b;
    b = V_RSVD;
    case (a)
      T_SIG0:   b = V_SIG0;
      T_SIG1:   b = V_SIG1;
      T_SIG2:   b = V_SIG2;
      T_SIG3:   b = V_SIG3;
      T_MINOR:  b = V_MINOR;
      T_MAJOR:  b = V_MAJOR;
      T_NHDR:   b = V_NHDR;
      T_BMAKER: b = MAKER_CODE;
      T_BMINOR: b = V_BMINOR;
      T_BMAJOR: b = V_BMAJOR;
      T_BLEN:   b = V_BLEN;
      T_BPTR0:  b = V_BPTR0;
      T_BPTR1:  b = V_BPTR1;
      T_BPTR2:  b = V_BPTR2;
      T_PMAKER: b = MAKER_CODE;
      T_PMINOR: b = V_PMINOR;
      T_PMAJOR: b = V_PMAJOR;
      T_PLEN:   b = V_PLEN;
      T_PPTR0:  b = V_PPTR0;
      T_PPTR1:  b = V_PPTR1;
      T_PPTR2:  b = V_PPTR2;
      default:  b = V_RSVD;
    endcase
    return b;
  endfunction

  // byte to send for the running instruction at position idx
  function automatic logic [7:0] out_byte(input logic [7:0] op,
                                          input logic [7:0] i);
    logic [63:0] w;
    logic [7:0]  b;
    w = UNIQUE_ID << {i[2:0], 3'h0};
    b = V_RSVD;
    case (op)
      OP_UNIQUE: b = w[63:56];
      OP_IDENT: begin
        case (i)
          8'h00:   b = MAKER_CODE;
          8'h01:   b = MEMORY_TYPE;
          8'h02:   b = CAPACITY;
          default: b = V_RSVD;
        endcase
      end
      OP_TABLE: b = table_byte(i);
      default:  b = V_RSVD;
    endcase
    return b;
  endfunction

  assign rise     = r.sclk_sync & ~r.sclk_prev;
  assign fall     = ~r.sclk_sync & r.sclk_prev;
  assign op_now   = {r.opcode[6:0], r.si_sync};
  assign cur_byte = out_byte(r.opcode, r.idx);

  always_comb begin
    next_r = r;
    next_r.sclk_meta = link.sclk;
    next_r.sclk_sync = r.sclk_meta;
    next_r.sclk_prev = r.sclk_sync;
    next_r.cs_meta   = link.cs_n;
    next_r.cs_sync   = r.cs_meta;
    next_r.si_meta   = link.mosi;
    next_r.si_sync   = r.si_meta;
    if (r.cs_sync) begin
      // deselected: release the line and rearm for a new opcode
      next_r.state      = D_OPC;
      next_r.bit_cnt    = 6'h00;
      next_r.out_bit    = 3'h0;
      next_r.idx        = 8'h00;
      next_r.miso       = 1'b0;
      next_r.miso_oe    = 1'b0;
      next_r.sleep_pend = 1'b0;
      next_r.wake_pend  = 1'b0;
      // power state only changes once the instruction is closed
      if (r.sleep_pend) begin
        next_r.sleep = 1'b1;
      end
      if (r.wake_pend) begin
        next_r.sleep = 1'b0;
      end
    end else begin
      case (r.state)
        D_OPC: begin
          if (rise) begin
            next_r.opcode  = op_now;
            next_r.bit_cnt = r.bit_cnt + 6'h01;
            if (r.bit_cnt == LAST_OPC_BIT) begin
              next_r.bit_cnt = 6'h00;
              next_r.state   = D_IGNORE;
              if (r.sleep) begin
                next_r.wake_pend = (op_now == OP_WAKE);
              end else begin
                case (op_now)
                  OP_UNIQUE: next_r.state = D_DUMMY;
                  OP_IDENT:  next_r.state = D_SEND;
                  OP_TABLE:  next_r.state = D_ADDR;
                  OP_SLEEP:  next_r.sleep_pend = 1'b1;
                  default:   next_r.state = D_IGNORE;
                endcase
              end
            end
          end
        end
        D_ADDR: begin
          if (rise) begin
            // only the low address byte is kept; upper bits are zero
            next_r.addr    = {r.addr[6:0], r.si_sync};
            next_r.bit_cnt = r.bit_cnt + 6'h01;
            if (r.bit_cnt == LAST_ADDR_BIT) begin
              next_r.bit_cnt = 6'h00;
              next_r.idx     = {r.addr[6:0], r.si_sync};
              next_r.state   = D_DUMMY;
            end
          end
        end
        D_DUMMY: begin
          if (rise) begin
            next_r.bit_cnt = r.bit_cnt + 6'h01;
            if ((r.opcode == OP_UNIQUE && r.bit_cnt == LAST_UID_DUMMY) ||
                (r.opcode == OP_TABLE && r.bit_cnt == LAST_TBL_DUMMY)) begin
              next_r.bit_cnt = 6'h00;
              next_r.state   = D_SEND;
            end
          end
        end
        D_SEND: begin
          // first falling edge after the header drives the msb
          if (fall) begin
            next_r.miso_oe = 1'b1;
            next_r.miso    = cur_byte[3'h7 - r.out_bit];
            next_r.out_bit = r.out_bit + 3'h1;
            if (r.out_bit == 3'h7) begin
              next_r.idx = r.idx + 8'h01;
            end
          end
        end
        D_IGNORE: begin
          next_r.state = D_IGNORE;
        end
        default: begin
          next_r.state = D_IGNORE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      r         <= '0;
      r.state   <= D_OPC;
      r.cs_meta <= 1'b1;
      r.cs_sync <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign link.miso_drv    = r.miso;
  assign link.miso_oe     = r.miso_oe;
  assign powered_down_out = r.sleep;

endmodule // fis_device

// file: design/fis_host.sv
// host end: apb-programmed controller issuing one read per start
// assumes software waits for busy low before starting the next read
`timescale 1ns/100ps
module fis_host
  import fis_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  fis_link_if.host         link
);

  typedef struct packed {
    logic        miso_meta;
    logic        miso_sync;
    fis_hstate_e state;
    logic [7:0]  op;
    logic [7:0]  addr;
    logic [7:0]  cnt;
    logic [39:0] tx;
    logic [5:0]  hdr_len;
    logic [11:0] clk_idx;
    logic [11:0] total;
    logic [2:0]  phase;
    logic [63:0] rx;
    logic        done;
    logic        cs_n;
    logic        sclk;
    logic        mosi;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } fis_host_s;

  fis_host_s  r;
  fis_host_s  next_r;
  logic       wr;
  logic       start;
  logic [7:0] new_op;
  logic [7:0] new_cnt;
  logic [5:0] new_hdr;

  // clocks sent before any data comes back
  function automatic logic [5:0] hdr_bits(input logic [7:0] op);
    return ((op == OP_TABLE) || (op == OP_UNIQUE)) ? HDR_LONG : HDR_SHORT;
  endfunction

  assign wr      = psel_in & penable_in & r.pready & pwrite_in;
  assign start   = wr && paddr_in == REG_CTRL && pwdata_in[CTRL_START] &&
                   r.state == H_IDLE;
  assign new_op  = pwdata_in[CTRL_OP_LSB +: 8];
  assign new_cnt = pwdata_in[CTRL_CNT_LSB +: 8];
  assign new_hdr = hdr_bits(new_op);

  always_comb begin
    next_r = r;
    next_r.miso_meta = link.miso_line;
    next_r.miso_sync = r.miso_meta;
    // zero-wait answer: ready in the access phase after every setup
    next_r.pready  = psel_in & ~penable_in;
    next_r.pslverr = 1'b0;
    next_r.prdata  = 32'h0000_0000;
    if (psel_in & ~penable_in) begin
      case (paddr_in)
        REG_CTRL:   next_r.prdata = {8'h00, r.cnt, r.addr, r.op};
        REG_STATUS: next_r.prdata = {30'h0, r.done, r.state != H_IDLE};
        REG_RX_LO:  next_r.prdata = r.rx[31:0];
        REG_RX_HI:  next_r.prdata = r.rx[63:32];
        default:    next_r.pslverr = 1'b1;
      endcase
    end
    if (wr && paddr_in == REG_STATUS && pwdata_in[ST_DONE]) begin
      next_r.done = 1'b0;
    end
    if (wr && paddr_in == REG_CTRL && r.state == H_IDLE) begin
      next_r.op   = pwdata_in[CTRL_OP_LSB +: 8];
      next_r.addr = pwdata_in[CTRL_ADDR_LSB +: 8];
      next_r.cnt  = pwdata_in[CTRL_CNT_LSB +: 8];
    end
    case (r.state)
      H_IDLE: begin
        if (start) begin
          // a new read forgets the previous completion
          next_r.state   = H_RUN;
          next_r.done    = 1'b0;
          next_r.hdr_len = new_hdr;
          next_r.total   = {6'h00, new_hdr} + {1'b0, new_cnt, 3'h0};
          // upper address bits go out as zero
          next_r.tx      = {new_op, 16'h0000,
                            pwdata_in[CTRL_ADDR_LSB +: 8], 8'h00};
          next_r.clk_idx = 12'h000;
          next_r.phase   = 3'h0;
          next_r.rx      = 64'h0000_0000_0000_0000;
          next_r.cs_n    = 1'b0;
          next_r.sclk    = 1'b0;
          next_r.mosi    = new_op[7];
        end
      end
      H_RUN: begin
        next_r.phase = r.phase + 3'h1;
        if (r.phase == PH_RISE) begin
          next_r.sclk = 1'b1;
        end
        if (r.phase == PH_LAST) begin
          // sample just before the fall: the answer crosses two
          // synchronisers, more than half a link period
          next_r.phase   = 3'h0;
          next_r.sclk    = 1'b0;
          next_r.clk_idx = r.clk_idx + 12'h001;
          next_r.tx      = {r.tx[38:0], 1'b0};
          next_r.mosi    = r.tx[38];
          if (r.clk_idx >= {6'h00, r.hdr_len}) begin
            next_r.rx = {r.rx[62:0], r.miso_sync};
          end
          if (r.clk_idx + 12'h001 == r.total) begin
            next_r.state = H_GAP;
            next_r.cs_n  = 1'b1;
            next_r.phase = 3'h0;
          end
        end
      end
      H_GAP: begin
        // select stays high long enough for the device to rearm
        next_r.phase = r.phase + 3'h1;
        if (r.phase == GAP_LAST) begin
          next_r.state = H_IDLE;
          next_r.done  = 1'b1;
        end
      end
      default: begin
        next_r.state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      r       <= '0;
      r.state <= H_IDLE;
      r.cs_n  <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign prdata_out  = r.prdata;
  assign pready_out  = r.pready;
  assign pslverr_out = r.pslverr;
  assign link.cs_n   = r.cs_n;
  assign link.sclk   = r.sclk;
  assign link.mosi   = r.mosi;

endmodule // fis_host

// file: verif/fis_link_props.sv
// link checker: watches the spi wires joining host and device
// assumes sclk is made by the host inside the clock_in domain
`timescale 1ns/100ps
module fis_link_props
  import fis_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_drv,
  input wire logic miso_oe
);
  logic       sclk_q;
  logic [7:0] rises;
  logic [7:0] opcode;
  logic       rise;

  assign rise = sclk && !sclk_q;

  // rising link edges per frame; saturates on long streams
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      sclk_q <= 1'b0;
      rises  <= 8'h00;
      opcode <= 8'h00;
    end else begin
      sclk_q <= sclk;
      if (cs_n)
        rises <= 8'h00;
      else if (rise && rises != 8'hff)
        rises <= rises + 8'h01;
      if (!cs_n && rise && rises < 8'h08)
        opcode <= {opcode[6:0], mosi};
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  sequence deselected;
    cs_n [*5];
  endsequence
  sequence drive_starts;
    $rose(miso_oe);
  endsequence
  sequence sclk_held;
    sclk && $past(sclk);
  endsequence

  chk_release_idle: assert property (deselected |-> !miso_oe)
    else $error("output driven while deselected");
  chk_drive_selected: assert property (drive_starts |-> !cs_n)
    else $error("output enabled without select");
  chk_ident_start: assert property (
    drive_starts ##0 opcode == OP_IDENT |-> rises == 8'(HDR_SHORT))
    else $error("identity data starts at wrong bit");
  chk_long_start: assert property (
    drive_starts ##0 opcode != OP_IDENT |-> rises == 8'(HDR_LONG))
    else $error("unique or table data starts at wrong bit");
  chk_miso_steady: assert property (
    sclk_held ##0 miso_oe |-> $stable(miso_drv))
    else $error("output changed while clock high");
  chk_mosi_steady: assert property (
    sclk_held ##0 !cs_n |-> $stable(mosi))
    else $error("input changed while clock high");
  chk_sclk_quiet: assert property (
    cs_n && $past(cs_n) |-> $stable(sclk))
    else $error("link clock moved outside a frame");
  chk_addr_zero: assert property (
    rise && opcode == OP_TABLE && rises >= 8'h08 && rises < 8'h18 |-> !mosi)
    else $error("upper table address bit not zero");
endmodule // fis_link_props

// file: verif/flash_id_sfdp_readout_tb_top.sv
// bench: host and device joined by the link, host driven over apb
// assumes the host packs received bytes first-in highest, right aligned
`timescale 1ns/100ps
module flash_id_sfdp_readout_tb_top
  import fis_pkg::*;
;
  typedef struct packed {
    logic [7:0]  op;
    logic [7:0]  addr;
    logic [7:0]  cnt;
    logic [63:0] exp;
  } fis_row_s;

  localparam fis_row_s ROWS [6] = '{
    '{OP_UNIQUE, 8'h00, 8'h08, UID_DEFAULT},
    '{OP_IDENT, 8'h00, 8'h03,
      {40'h0, MAKER_DEFAULT, MEMTYPE_DEF, CAPACITY_DEF}},
    '{OP_TABLE, 8'h00, 8'h04, 64'h53464450},
    '{OP_TABLE, 8'h04, 8'h04, 64'h010100ff},
    '{OP_TABLE, 8'h08, 8'h08,
      {MAKER_DEFAULT, 56'h000104800000ff}},
    '{OP_TABLE, 8'h10, 8'h08,
      {MAKER_DEFAULT, 56'h000100900000ff}}
  };

  logic        clock_in     = 1'b0;
  logic        reset_n_in   = 1'b0;
  logic        psel         = 1'b0;
  logic        penable      = 1'b0;
  logic        pwrite       = 1'b0;
  logic [7:0]  paddr        = 8'h00;
  logic [31:0] pwdata       = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        asleep;
  logic        asleep_drive = 1'b0;
  logic [31:0] q;
  logic        perr;
  logic [63:0] rx;
  int          num_errors   = 0;
  int          tests_run    = 0;
  int          cycles       = 0;

  fis_link_if link();
  fis_device i_fis_device (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .link(link), .powered_down_out(asleep));
  fis_host i_fis_host (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .link(link));
  fis_link_props i_fis_link_props (.clock_in(clock_in),
    .reset_n_in(reset_n_in), .cs_n(link.cs_n), .sclk(link.sclk),
    .mosi(link.mosi), .miso_drv(link.miso_drv), .miso_oe(link.miso_oe));

  initial begin
    forever #50 clock_in = ~clock_in;
  end

  // a sleeping device must never enable its output
  always @(posedge clock_in) begin
    if (asleep === 1'b1 && link.miso_oe === 1'b1)
      asleep_drive <= 1'b1;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ceiling well above the dozen reads of this run
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic chk_word(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [63:0] mask(input logic [7:0] n);
    return n[3] ? 64'hffffffff_ffffffff : (64'h1 << (n * 8)) - 64'h1;
  endfunction

  // entered just after a rising edge; leaves one idle cycle behind
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    @(posedge clock_in);
    while (pready !== 1'b1) begin
      @(posedge clock_in);
    end
    q    = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_in);
  endtask

  task automatic do_read(input logic [7:0] op, addr, cnt);
    apb(1'b1, REG_CTRL, {8'h80, cnt, addr, op});
    do begin
      apb(1'b0, REG_STATUS, 32'h0);
    end while (q[ST_BUSY] !== 1'b0 || q[ST_DONE] !== 1'b1);
    apb(1'b0, REG_RX_LO, 32'h0);
    rx[31:0] = q;
    apb(1'b0, REG_RX_HI, 32'h0);
    rx[63:32] = q;
    $display("test op %h addr %h done", op, addr);
  endtask

  initial begin
    repeat (5) @(posedge clock_in);
    reset_n_in <= 1'b1;
    @(posedge clock_in);
    foreach (ROWS[i]) begin
      do_read(ROWS[i].op, ROWS[i].addr, ROWS[i].cnt);
      chk_word(rx & mask(ROWS[i].cnt), ROWS[i].exp);
      chk_bit(link.miso_oe, 1'b0);
    end
    do_read(OP_SLEEP, 8'h00, 8'h00);
    repeat (20) @(posedge clock_in);
    chk_bit(asleep, 1'b1);
    do_read(OP_IDENT, 8'h00, 8'h03);
    chk_bit(asleep_drive, 1'b0);
    chk_word(rx & mask(8'h03), 64'h0000_0000_00ff_ffff);
    do_read(OP_WAKE, 8'h00, 8'h00);
    repeat (20) @(posedge clock_in);
    chk_bit(asleep, 1'b0);
    do_read(OP_IDENT, 8'h00, 8'h03);
    chk_word(rx & mask(8'h03), ROWS[1].exp);
    // reset lands while unique-number bits are on the wire
    apb(1'b1, REG_CTRL, {8'h80, 8'h08, 8'h00, OP_UNIQUE});
    repeat (400) @(posedge clock_in);
    reset_n_in <= 1'b0;
    repeat (5) @(posedge clock_in);
    reset_n_in <= 1'b1;
    @(posedge clock_in);
    chk_bit(link.miso_oe, 1'b0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk_bit(q[ST_BUSY], 1'b0);
    $display("test mid-read reset done");
    do_read(OP_UNIQUE, 8'h00, 8'h08);
    chk_word(rx, UID_DEFAULT);
    apb(1'b0, REG_CTRL, 32'h0);
    chk_word({32'h0, q}, {40'h0, 8'h08, 8'h00, OP_UNIQUE});
    apb(1'b1, REG_STATUS, 32'h1 << ST_DONE);
    apb(1'b0, REG_STATUS, 32'h0);
    chk_bit(q[ST_DONE], 1'b0);
    $display("test register access done");
    apb(1'b0, 8'h40, 32'h0);
    chk_bit(perr, 1'b1);
    $display("test unmapped read done");
    conclude();
  end
endmodule // flash_id_sfdp_readout_tb_top
